// ===== testbench/ppr_host.sv
/* Host model: single-cycle register strobes standing for the serial engine.
   Assumes the bench calls its tasks at a falling edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module ppr_host (
    input  wire logic           sys_clk,
    input  wire logic [7:0]     rdata,
    output var ppr_pkg::ppr_reg_req_t req
);
    import ppr_pkg::*;
    // ======================================================================
    // Idle bus shows inverted data so stale values never look valid
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        d = rdata;
    endtask
endmodule // ppr_host
`default_nettype wire

// ===== testbench/ppr_port_policy_regs_tb.sv
/* Self-checking bench for the port policy register bank.
   Assumes ppr_host as register master and the bound assertion checker. */
`timescale 1ns/1ps
`default_nettype none
module ppr_port_policy_regs_tb;
    import ppr_pkg::*;
    logic sys_clk, rst_b, hc_strap, am_strap, cap_hit, ia, ib, clr_all, cap_en, conv_en, wd_en;
    logic [1:0] irq_ev;
    logic [3:0] powered, hce, tse, go, l40;
    logic [7:0] rdata, rank;
    ppr_cls_res_t [3:0] fcls;
    ppr_reg_req_t req;
    ppr_shed_t shed;
    int bad_count, total_checks;
    ppr_port_policy_regs i_ppr_port_policy_regs (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(req),
        .reg_rdata(rdata), .high_class_strap(hc_strap), .auto_mode_strap(am_strap),
        .first_class(fcls), .irq_event(irq_ev), .port_powered(powered), .total_power_cap(cap_hit),
        .high_class_enable(hce), .two_step_class_enable(tse), .second_class_go(go),
        .limit_40w_select(l40), .shed_rank(rank), .shed_req(shed), .irq_out_a(ia), .irq_out_b(ib),
        .irq_source_clear_all(clr_all), .power_cap_enable(cap_en), .converter_enable(conv_en),
        .bus_watchdog_enable(wd_en));
    ppr_host i_ppr_host (.sys_clk(sys_clk), .rdata(rdata), .req(req));
    // ======================================================================
    // Helpers
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_ppr_host.rd(a, v);
        chk("reg_rdata", e, v);
    endtask
    task automatic do_reset(input logic hc, input logic am);
        hc_strap = hc;
        am_strap = am;
        rst_b = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_defaults();
        rdchk(8'h0C, 8'hFF);
        rdchk(8'h0D, 8'hE4);
        rdchk(8'h0E, 8'h01);
        rdchk(8'h0F, 8'h06);
        chk("general_enables", 8'h06, {5'h00, cap_en, conv_en, wd_en});
        chk("shed_rank", 8'hE4, rank);
        do_reset(1'b0, 1'b1);
        rdchk(8'h0C, 8'h0F);
        rdchk(8'h0F, 8'h06);
        do_reset(1'b1, 1'b0);
        rdchk(8'h0C, 8'hF0);
        rdchk(8'h0F, 8'h02);
        chk("power_cap_enable", 8'h00, {7'h00, cap_en});
        do_reset(1'b1, 1'b1);
        $display("test defaults done");
    endtask
    task automatic t_regs();
        i_ppr_host.wr(8'h0F, 8'hFA);
        rdchk(8'h0F, 8'h02);
        i_ppr_host.wr(8'h0F, 8'h07);
        chk("bus_watchdog_enable", 8'h01, {7'h00, wd_en});
        i_ppr_host.wr(8'h0E, 8'hF8);
        rdchk(8'h0E, 8'h00);
        i_ppr_host.wr(8'h20, 8'hFF);
        rdchk(8'h20, 8'h00);
        rdchk(8'h0D, 8'hE4);
        i_ppr_host.wr(8'h0C, 8'hA1);
        chk("high_class_enable", 8'hAA, {hce, l40});
        $display("test registers done");
    endtask
    task automatic t_class();
        chk("two_step_class_enable", 8'h01, {4'h0, tse});
        for (int c = 3; c <= 5; c++) begin
            fcls[0] = '{valid: 1'b1, cls: 3'(c)};
            fcls[1] = '{valid: 1'b1, cls: 3'(c)};
            @(negedge sys_clk);
            chk("second_class_go", (c >= 4) ? 8'h01 : 8'h00, {4'h0, go});
            fcls = '0;
            @(negedge sys_clk);
            chk("second_class_go_end", 8'h00, {4'h0, go});
        end
        $display("test classification done");
    endtask
    task automatic t_shed();
        cap_hit = 1'b1;
        powered = 4'hF;
        i_ppr_host.wr(8'h0D, 8'h00);
        @(negedge sys_clk);
        chk("shed_req", 8'h18, {3'h0, shed.valid, shed.port});
        i_ppr_host.wr(8'h0D, 8'h1B);
        @(negedge sys_clk);
        chk("shed_req", 8'h11, {3'h0, shed.valid, shed.port});
        powered = 4'h6;
        i_ppr_host.wr(8'h0D, 8'hE4);
        @(negedge sys_clk);
        chk("shed_req", 8'h14, {3'h0, shed.valid, shed.port});
        i_ppr_host.wr(8'h0F, 8'h03);
        @(negedge sys_clk);
        chk("shed_req_valid", 8'h00, {7'h00, shed.valid});
        cap_hit = 1'b0;
        $display("test shedding done");
    endtask
    task automatic t_irq();
        irq_ev = 2'h1;
        @(negedge sys_clk);
        irq_ev = 2'h0;
        @(negedge sys_clk);
        chk("irq_out_a", 8'h00, {7'h00, ia});
        i_ppr_host.wr(8'h0E, 8'h01);
        @(negedge sys_clk);
        chk("irq_out_a", 8'h01, {7'h00, ia});
        i_ppr_host.wr(8'h0E, 8'h05);
        @(negedge sys_clk);
        chk("irq_pins", 8'h00, {6'h00, ia, ib});
        rdchk(8'h0E, 8'h01);
        irq_ev = 2'h2;
        @(negedge sys_clk);
        irq_ev = 2'h0;
        @(negedge sys_clk);
        chk("irq_out_b", 8'h01, {7'h00, ib});
        i_ppr_host.wr(8'h0E, 8'h03);
        @(negedge sys_clk);
        chk("clear_all_and_pins", 8'h04, {5'h00, clr_all, ia, ib});
        rdchk(8'h0E, 8'h01);
        $display("test interrupts done");
    endtask
    // ======================================================================
    // Clock, watchdog and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst_b, hc_strap, am_strap, cap_hit, irq_ev, powered} = '0;
        fcls = '0;
        bad_count = 0;
        total_checks = 0;
        do_reset(1'b1, 1'b1);
        t_defaults();
        t_regs();
        t_class();
        t_shed();
        t_irq();
        wrap_up();
    end
endmodule // ppr_port_policy_regs_tb
`default_nettype wire

// ===== testbench/ppr_regs_chk_sva.sv
/* Assertion checker for the port policy register bank.
   Assumes one sys_clk domain, async active-low rst_b, and a bind by port name. */
`timescale 1ns/1ps
`default_nettype none
module ppr_regs_chk (
    input wire logic                        sys_clk,
    input wire logic                        rst_b,
    input wire ppr_pkg::ppr_reg_req_t       reg_req,
    input wire logic [7:0]                  reg_rdata,
    input wire logic                        high_class_strap,
    input wire logic                        auto_mode_strap,
    input wire ppr_pkg::ppr_cls_res_t [3:0] first_class,
    input wire logic [1:0]                  irq_event,
    input wire logic [3:0]                  port_powered,
    input wire logic                        total_power_cap,
    input wire logic [3:0]                  high_class_enable,
    input wire logic [3:0]                  two_step_class_enable,
    input wire logic [3:0]                  second_class_go,
    input wire logic [3:0]                  limit_40w_select,
    input wire logic [7:0]                  shed_rank,
    input wire ppr_pkg::ppr_shed_t          shed_req,
    input wire logic                        irq_out_a,
    input wire logic                        irq_out_b,
    input wire logic                        irq_source_clear_all,
    input wire logic                        power_cap_enable,
    input wire logic                        converter_enable,
    input wire logic                        bus_watchdog_enable
);
    import ppr_pkg::*;
    // ======================================================================
    // Properties; reset disables all, mid-run resets included
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic w_irq;
    assign w_irq = reg_req.wr && reg_req.addr == 8'h0E;
    AST_STRAP_LOAD: assert property (!$past(rst_b) |=> {high_class_enable,
        two_step_class_enable, power_cap_enable} == {{4{$past(high_class_strap)}},
        {4{$past(auto_mode_strap)}}, $past(auto_mode_strap)}) else $error("strap load wrong");
    AST_HIGH_CLASS: assert property (reg_req.wr && reg_req.addr == 8'h0C |=>
        high_class_enable == $past(reg_req.wdata[7:4]) && limit_40w_select == high_class_enable)
        else $error("high class enable wrong");
    AST_SECOND_GO: assert property (first_class[0].valid && two_step_class_enable[0] &&
        first_class[0].cls inside {3'h4, 3'h5} |=> second_class_go[0])
        else $error("second class step missing");
    AST_RD_RANK: assert property (reg_req.rd && !reg_req.wr && reg_req.addr == 8'h0D |=>
        reg_rdata == $past(shed_rank)) else $error("rank readback wrong");
    AST_SHED_TIE: assert property (total_power_cap && power_cap_enable &&
        port_powered == 4'hF && shed_rank == 8'h00 |=> shed_req.valid && shed_req.port == 4'h8)
        else $error("tie not shed from highest port");
    AST_SHED_OFF: assert property (!power_cap_enable |=> !shed_req.valid)
        else $error("shed while cap disabled");
    AST_PIN_CLEAR: assert property (w_irq && reg_req.wdata[2] && !(|irq_event) ##1
        !(|irq_event) |=> !irq_out_a && !irq_out_b) else $error("pins not cleared");
    AST_CLEAR_ALL: assert property (w_irq && reg_req.wdata[1] |-> ##2 irq_source_clear_all)
        else $error("clear-all pulse missing");
    AST_IRQ_GATE: assert property (w_irq && !reg_req.wdata[0] |=> !irq_out_a && !irq_out_b)
        else $error("pin high while disabled");
    AST_GEN_WR: assert property (reg_req.wr && reg_req.addr == 8'h0F |=> {power_cap_enable,
        converter_enable, bus_watchdog_enable} == $past(reg_req.wdata[2:0]))
        else $error("general enables wrong");
    AST_RSV_ZERO: assert property (reg_req.rd && reg_req.addr[7:1] == 7'h07 |=>
        reg_rdata[7:3] == 5'h00) else $error("reserved bits not zero");
    cover property (shed_req.valid);
    cover property (second_class_go[0]);
    cover property (irq_source_clear_all);
endmodule // ppr_regs_chk
bind ppr_port_policy_regs ppr_regs_chk i_ppr_regs_chk (.*);
`default_nettype wire

// ===== verilog/ppr_params.svh
/*
 * Offsets, field positions and reset values of the port policy register bank.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH

// ==========================================================================
// Register offsets
`define PPR_OFS_CLASS_OPT     8'h0C
`define PPR_OFS_SHED_PRIO     8'h0D
`define PPR_OFS_IRQ_CTRL      8'h0E
`define PPR_OFS_GEN_CTRL      8'h0F

// ==========================================================================
// Field positions
`define PPR_POS_HIGH_CLASS    4
`define PPR_POS_TWO_STEP      0
`define PPR_POS_PIN_CLEAR     2
`define PPR_POS_CLEAR_ALL     1
`define PPR_POS_IRQ_EN        0
`define PPR_POS_CAP_EN        2
`define PPR_POS_CONV_EN       1
`define PPR_POS_WDOG_EN       0

// ==========================================================================
// Reset values and codes
`define PPR_RST_SHED_PRIO     8'hE4
`define PPR_RST_IRQ_EN        1'h1
`define PPR_RST_CONV_EN       1'h1
`define PPR_RST_WDOG_EN       1'h0
`define PPR_CLASS_FOUR        3'h4
`define PPR_CLASS_FIVE        3'h5

`endif

// ===== verilog/ppr_pkg.sv
/*
 * Types shared by the port policy register bank and its shed picker.
 * Assumes ppr_params.svh is on the include path.
 */
`default_nettype none
package ppr_pkg;

    // ======================================================================
    // Register access request from the serial control bus engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppr_reg_req_t;

    // ======================================================================
    // First classification result of one port
    typedef struct packed {
        logic       valid;
        logic [2:0] cls;
    } ppr_cls_res_t;

    // ======================================================================
    // Shed request toward the port power engine
    typedef struct packed {
        logic       valid;
        logic [3:0] port;
    } ppr_shed_t;

endpackage

`default_nettype wire

// ===== verilog/ppr_port_policy_regs.sv
/*
 * Per-port policy and global control registers of a quad-port PoE source:
 * high-class and two-step classification enables, power shed ranking,
 * interrupt pin control and general enables.
 * Assumes a serial bus engine that hands over single-cycle register
 * requests, and strap pins that are steady around reset release.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppr_params.svh"

module ppr_port_policy_regs (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire ppr_pkg::ppr_reg_req_t reg_req,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  high_class_strap,
    input  wire logic                  auto_mode_strap,
    input  wire ppr_pkg::ppr_cls_res_t [3:0] first_class,
    input  wire logic [1:0]            irq_event,
    input  wire logic [3:0]            port_powered,
    input  wire logic                  total_power_cap,
    output logic [3:0]                 high_class_enable,
    output logic [3:0]                 two_step_class_enable,
    output logic [3:0]                 second_class_go,
    output logic [3:0]                 limit_40w_select,
    output logic [7:0]                 shed_rank,
    output ppr_pkg::ppr_shed_t         shed_req,
    output logic                       irq_out_a,
    output logic                       irq_out_b,
    output logic                       irq_source_clear_all,
    output logic                       power_cap_enable,
    output logic                       converter_enable,
    output logic                       bus_watchdog_enable
);
    import ppr_pkg::*;

    // ======================================================================
    // Module state
    // Every flop of the block lives here so reset and update stay in one place
    typedef struct packed {
        logic       strap_load;  // One pending load of strap defaults
        logic [3:0] hc_en;
        logic [3:0] ts_en;
        logic [7:0] rank;
        logic       pin_clear;
        logic       clear_all;
        logic       irq_en;
        logic       cap_en;
        logic       conv_en;
        logic       wdog_en;
        logic [1:0] irq_latch;   // Pending interrupt requests, pins show gated copy
        logic [1:0] irq_pin;
        logic       src_clr;
        logic [3:0] cls_go;
        ppr_shed_t  shed;
        logic [7:0] rdata;
    } ppr_state_t;

    ppr_state_t st_ff;
    ppr_state_t nxt_st;
    logic [3:0] shed_pick;

    // ======================================================================
    // Shed order picker
    // Combinational; its answer is registered through the shed field below
    ppr_shed_pick u_pick (
        .shed_rank (st_ff.rank),
        .powered   (port_powered),
        .pick      (shed_pick)
    );

    // Address match shared by write and read paths
    // Exact compare, so aliases of the four offsets never hit
    function automatic logic hit(input ppr_reg_req_t q, input logic [7:0] ofs);
        hit = (q.addr == ofs);
    endfunction

    // ======================================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;

        // Straps are sampled on the first edge after reset release, since an
        // async reset may only load constants. A host write in that same
        // cycle is applied after the strap load and so takes precedence;
        // hosts are expected to wait a couple of cycles after reset.
        if (st_ff.strap_load) begin
            nxt_st.strap_load = 1'b0;
            nxt_st.hc_en      = {4{high_class_strap}};
            nxt_st.ts_en      = {4{auto_mode_strap}};
            nxt_st.cap_en     = auto_mode_strap;
        end

        // Self-clearing commands drop once the pins have been cleared.
        // They live for exactly the one cycle in which they act on the latch,
        // so a read in that cycle still shows the command in flight.
        nxt_st.pin_clear = 1'b0;
        nxt_st.clear_all = 1'b0;

        // Register writes; reserved bits are never stored
        // Unmapped offsets miss every hit() test and change nothing
        if (reg_req.wr) begin
            if (hit(reg_req, `PPR_OFS_CLASS_OPT)) begin
                nxt_st.hc_en = reg_req.wdata[`PPR_POS_HIGH_CLASS +: 4];
                nxt_st.ts_en = reg_req.wdata[`PPR_POS_TWO_STEP +: 4];
            end
            if (hit(reg_req, `PPR_OFS_SHED_PRIO)) begin
                nxt_st.rank = reg_req.wdata;
            end
            if (hit(reg_req, `PPR_OFS_IRQ_CTRL)) begin
                nxt_st.pin_clear = reg_req.wdata[`PPR_POS_PIN_CLEAR];
                nxt_st.clear_all = reg_req.wdata[`PPR_POS_CLEAR_ALL];
                nxt_st.irq_en    = reg_req.wdata[`PPR_POS_IRQ_EN];
            end
            if (hit(reg_req, `PPR_OFS_GEN_CTRL)) begin
                nxt_st.cap_en  = reg_req.wdata[`PPR_POS_CAP_EN];
                nxt_st.conv_en = reg_req.wdata[`PPR_POS_CONV_EN];
                nxt_st.wdog_en = reg_req.wdata[`PPR_POS_WDOG_EN];
            end
        end

        // Interrupt latch: a clear command acts the cycle after its write;
        // an event in that same cycle wins so it is not lost.
        // The latch is only the pin-side copy; the event registers sit
        // outside and are wiped through irq_source_clear_all, never here,
        // so a pin clear alone leaves every recorded event in place.
        if (st_ff.pin_clear || st_ff.clear_all) begin
            nxt_st.irq_latch = 2'h0;
        end
        nxt_st.irq_latch = nxt_st.irq_latch | irq_event;
        // Events are still recorded outside; only the pins are gated
        nxt_st.irq_pin   = nxt_st.irq_latch & {2{nxt_st.irq_en}};
        nxt_st.src_clr   = st_ff.clear_all;

        // Second classification step only after a class 4 or 5 result
        // A result that arrives while the enable is low is dropped, not
        // queued; the engine must present a fresh result after enabling.
        for (int p = 0; p < 4; p++) begin
            nxt_st.cls_go[p] = st_ff.ts_en[p] && first_class[p].valid &&
                               (first_class[p].cls == `PPR_CLASS_FOUR ||
                                first_class[p].cls == `PPR_CLASS_FIVE);
        end

        // Power cap trip sheds the chosen powered port
        // Only powered ports are offered to the picker, so a request always
        // names a port that can be shut; it repeats while the cap stays hit and cap_en is set.
        nxt_st.shed.valid = st_ff.cap_en && total_power_cap && (|port_powered);
        nxt_st.shed.port  = nxt_st.shed.valid ? shed_pick : 4'h0;

        // Read data, reserved bits as zero
        // Held in a flop until the next read, so the host may fetch it late
        nxt_st.rdata = st_ff.rdata;
        if (reg_req.rd) begin
            nxt_st.rdata = 8'h00;
            if (hit(reg_req, `PPR_OFS_CLASS_OPT)) begin
                nxt_st.rdata = {st_ff.hc_en, st_ff.ts_en};
            end
            if (hit(reg_req, `PPR_OFS_SHED_PRIO)) begin
                nxt_st.rdata = st_ff.rank;
            end
            if (hit(reg_req, `PPR_OFS_IRQ_CTRL)) begin
                nxt_st.rdata = {5'h00, st_ff.pin_clear, st_ff.clear_all,
                                st_ff.irq_en};
            end
            if (hit(reg_req, `PPR_OFS_GEN_CTRL)) begin
                nxt_st.rdata = {5'h00, st_ff.cap_en, st_ff.conv_en,
                                st_ff.wdog_en};
            end
        end
    end

    // ======================================================================
    // State register; strap-dependent fields start cleared and load next edge
    // Only constants in the reset branch; straps arrive through strap_load
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff            <= '0;
            st_ff.strap_load <= 1'b1;
            st_ff.rank       <= `PPR_RST_SHED_PRIO;
            st_ff.irq_en     <= `PPR_RST_IRQ_EN;
            st_ff.conv_en    <= `PPR_RST_CONV_EN;
            st_ff.wdog_en    <= `PPR_RST_WDOG_EN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ======================================================================
    // Outputs straight from the state flops
    // The 40 W select mirrors the high-class enables as its own port, so the
    // current-limit engine needs no knowledge of classification.
    assign reg_rdata             = st_ff.rdata;
    assign high_class_enable     = st_ff.hc_en;
    assign limit_40w_select      = st_ff.hc_en;
    assign two_step_class_enable = st_ff.ts_en;
    assign second_class_go       = st_ff.cls_go;
    assign shed_rank             = st_ff.rank;
    assign shed_req              = st_ff.shed;
    assign irq_out_a             = st_ff.irq_pin[0];
    assign irq_out_b             = st_ff.irq_pin[1];
    assign irq_source_clear_all  = st_ff.src_clr;
    assign power_cap_enable      = st_ff.cap_en;
    assign converter_enable      = st_ff.conv_en;
    assign bus_watchdog_enable   = st_ff.wdog_en;

endmodule // ppr_port_policy_regs

`default_nettype wire

// ===== verilog/ppr_shed_pick.sv
/*
 * Chooses which powered port is shut next when the total power cap trips.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module ppr_shed_pick (
    input  wire logic [7:0] shed_rank,
    input  wire logic [3:0] powered,
    output logic      [3:0] pick
);
    import ppr_pkg::*;

    // ======================================================================
    // Score = rank code then port number, so ties favour the higher port
    function automatic logic [3:0] score(input logic [7:0] r, input int p);
        score = {r[2*p +: 2], 2'(p)};
    endfunction

    logic [3:0] best;
    logic       found;

    // Scan all ports, keep the highest score among powered ones
    always_comb begin
        pick  = 4'h0;
        best  = 4'h0;
        found = 1'b0;
        for (int p = 0; p < 4; p++) begin
            if (powered[p] && (!found || score(shed_rank, p) > best)) begin
                best  = score(shed_rank, p);
                pick  = 4'(1 << p);
                found = 1'b1;
            end
        end
    end

endmodule // ppr_shed_pick

`default_nettype wire
